// ---- i2crt_bus_peer.sv ----
// bus peer model: pull-ups, wired-and lines, optional clock stretch
`timescale 1ns/1ps
module i2crt_bus_peer (
    // clock
    input wire logic clk,
    // device pin enables
    input wire logic sclOe,
    input wire logic sdaOe,
    // peer control
    input wire logic stretch,
    // resolved wire levels
    output logic scl,
    output logic sda
);
    logic holdLow;
    always_ff @(posedge clk) begin
        holdLow <= stretch && sclOe;
    end
    // peer keeps scl low one cycle longer when stretching
    assign scl = !(sclOe || holdLow);
    assign sda = !sdaOe;
endmodule : i2crt_bus_peer

// ---- i2crt_pkg.sv ----
// constants, types and rate table for the two-wire rate and control block
package i2crt_pkg;
    // register byte offsets
    localparam logic [7:0] RATE_OFS = 8'h00;
    localparam logic [7:0] CTRL_OFS = 8'h04;
    localparam logic [7:0] STAT_OFS = 8'h08;
    localparam logic [7:0] MASK_OFS = 8'h0c;
    // control bit positions
    localparam int CTRL_EN = 7;
    localparam int CTRL_IE = 6;
    localparam int CTRL_MS = 5;
    localparam int CTRL_TX = 4;
    localparam int CTRL_ACKS = 3;
    localparam int CTRL_RS = 2;
    // rate register fields
    localparam int RATE_MULTIPLIER_HI = 7;
    localparam int RATE_MULTIPLIER_LO = 6;
    localparam int CODE_HI = 5;
    localparam logic [1:0] RATE_MULTIPLIER_X2 = 2'h1;
    localparam logic [1:0] RATE_MULTIPLIER_X4 = 2'h2;
    // status bit positions, sticky bits are 3..0
    localparam int ST_BYTE = 0;
    localparam int ST_ARB = 1;
    localparam int ST_START = 2;
    localparam int ST_STOP = 3;
    localparam int ST_MSTR = 4;
    // reset values
    localparam logic [7:0] RATE_RST = 8'h00;
    localparam logic [7:0] CTRL_RST = 8'h00;
    localparam logic [7:0] MASK_RST = 8'h00;
    localparam logic [7:0] STAT_RST = 8'h00;
    // index of the acknowledge clock within a byte
    localparam logic [3:0] ACK_SLOT = 4'h8;

    typedef enum logic [2:0] {
        ST_IDLE, ST_START_HOLD, ST_LOW, ST_HIGH, ST_STOP_HIGH, ST_RS_HIGH
    } i2crt_state_t;

    typedef enum logic [1:0] {ACT_NONE, ACT_STOP, ACT_RS} i2crt_act_t;

    typedef struct packed {
        logic [11:0] div;
        logic [9:0] sda;
        logic [10:0] start;
        logic [10:0] stop;
    } i2crt_hold_t;

    function automatic i2crt_hold_t hold_ent(input int d, input int s, input int a, input int p);
        hold_ent = '{d[11:0], s[9:0], a[10:0], p[10:0]};
    endfunction : hold_ent

    // divider, sda hold, start hold, stop hold per rate code
    function automatic i2crt_hold_t hold_lookup(input logic [5:0] code);
        case (code)
            6'h00: hold_lookup = hold_ent(20, 7, 6, 11);
            6'h01: hold_lookup = hold_ent(22, 7, 7, 12);
            6'h02: hold_lookup = hold_ent(24, 8, 8, 13);
            6'h03: hold_lookup = hold_ent(26, 8, 9, 14);
            6'h04: hold_lookup = hold_ent(28, 9, 10, 15);
            6'h05: hold_lookup = hold_ent(30, 9, 11, 16);
            6'h06: hold_lookup = hold_ent(34, 10, 13, 18);
            6'h07: hold_lookup = hold_ent(40, 10, 16, 21);
            6'h08: hold_lookup = hold_ent(28, 7, 10, 15);
            6'h09: hold_lookup = hold_ent(32, 7, 12, 17);
            6'h0a: hold_lookup = hold_ent(36, 9, 14, 19);
            6'h0b: hold_lookup = hold_ent(40, 9, 16, 21);
            6'h0c: hold_lookup = hold_ent(44, 11, 18, 23);
            6'h0d: hold_lookup = hold_ent(48, 11, 20, 25);
            6'h0e: hold_lookup = hold_ent(56, 13, 24, 29);
            6'h0f: hold_lookup = hold_ent(68, 13, 30, 35);
            6'h10: hold_lookup = hold_ent(48, 9, 18, 25);
            6'h11: hold_lookup = hold_ent(56, 9, 22, 29);
            6'h12: hold_lookup = hold_ent(64, 13, 26, 33);
            6'h13: hold_lookup = hold_ent(72, 13, 30, 37);
            6'h14: hold_lookup = hold_ent(80, 17, 34, 41);
            6'h15: hold_lookup = hold_ent(88, 17, 38, 45);
            6'h16: hold_lookup = hold_ent(104, 21, 46, 53);
            6'h17: hold_lookup = hold_ent(128, 21, 58, 65);
            6'h18: hold_lookup = hold_ent(80, 9, 38, 41);
            6'h19: hold_lookup = hold_ent(96, 9, 46, 49);
            6'h1a: hold_lookup = hold_ent(112, 17, 54, 57);
            6'h1b: hold_lookup = hold_ent(128, 17, 62, 65);
            6'h1c: hold_lookup = hold_ent(144, 25, 70, 73);
            6'h1d: hold_lookup = hold_ent(160, 25, 78, 81);
            6'h1e: hold_lookup = hold_ent(192, 33, 94, 97);
            6'h1f: hold_lookup = hold_ent(240, 33, 118, 121);
            6'h20: hold_lookup = hold_ent(160, 17, 78, 81);
            6'h21: hold_lookup = hold_ent(192, 17, 94, 97);
            6'h22: hold_lookup = hold_ent(224, 33, 110, 113);
            6'h23: hold_lookup = hold_ent(256, 33, 126, 129);
            6'h24: hold_lookup = hold_ent(288, 49, 142, 145);
            6'h25: hold_lookup = hold_ent(320, 49, 158, 161);
            6'h26: hold_lookup = hold_ent(384, 65, 190, 193);
            6'h27: hold_lookup = hold_ent(480, 65, 238, 241);
            6'h28: hold_lookup = hold_ent(320, 33, 158, 161);
            6'h29: hold_lookup = hold_ent(384, 33, 190, 193);
            6'h2a: hold_lookup = hold_ent(448, 65, 222, 225);
            6'h2b: hold_lookup = hold_ent(512, 65, 254, 257);
            6'h2c: hold_lookup = hold_ent(576, 97, 286, 289);
            6'h2d: hold_lookup = hold_ent(640, 97, 318, 321);
            6'h2e: hold_lookup = hold_ent(768, 129, 382, 385);
            6'h2f: hold_lookup = hold_ent(960, 129, 478, 481);
            6'h30: hold_lookup = hold_ent(640, 65, 318, 321);
            6'h31: hold_lookup = hold_ent(768, 65, 382, 385);
            6'h32: hold_lookup = hold_ent(896, 129, 446, 449);
            6'h33: hold_lookup = hold_ent(1024, 129, 510, 513);
            6'h34: hold_lookup = hold_ent(1152, 193, 574, 577);
            6'h35: hold_lookup = hold_ent(1280, 193, 638, 641);
            6'h36: hold_lookup = hold_ent(1536, 257, 766, 769);
            6'h37: hold_lookup = hold_ent(1920, 257, 958, 961);
            6'h38: hold_lookup = hold_ent(1280, 129, 638, 641);
            6'h39: hold_lookup = hold_ent(1536, 129, 766, 769);
            6'h3a: hold_lookup = hold_ent(1792, 257, 894, 897);
            6'h3b: hold_lookup = hold_ent(2048, 257, 1022, 1025);
            6'h3c: hold_lookup = hold_ent(2304, 385, 1150, 1153);
            6'h3d: hold_lookup = hold_ent(2560, 385, 1278, 1281);
            6'h3e: hold_lookup = hold_ent(3072, 513, 1534, 1537);
            default: hold_lookup = hold_ent(3840, 513, 1918, 1921);
        endcase
    endfunction : hold_lookup
endpackage : i2crt_pkg

// ---- i2crt_rate_ctrl.sv ----
// two-wire rate generator, control register and start/stop sequencer
// Operation
// - rate code selects divider and three hold counts from table, divider 20..3840.
// - module enable clear disables the interface; set lets it run.
// - interrupt output only while interrupt enable bit is set.
// - master select 0 to 1 makes a start and enters master mode.
// - master select 1 to 0 makes a stop and returns to slave.
// - direction bit: 0 receive, 1 transmit.
// - receive acknowledge slot drives sda low unless acknowledge suppress is set.
// - writing repeat start request makes repeated start, only while master.
// - repeat start request bit always reads zero.
// - repeat start at improper point counts as lost arbitration.
// - multiplier code 00, 01, 10 give factor 1, 2, 4; 11 reserved.
// - scl period is bus period times multiplier times divider.
// - hold delays are bus period times multiplier times hold count.
//
// Decided for this implementation: the register addresses and the APB register port.
`timescale 1ns/1ps
module i2crt_rate_ctrl (
    // clock and reset
    input wire logic clk,
    input wire logic reset_n,
    // apb slave
    input wire logic [7:0] paddr,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // open-drain bus pins
    input wire logic sclIn,
    output logic sclOut,
    output logic sclOe,
    input wire logic sdaIn,
    output logic sdaOut,
    output logic sdaOe,
    // interrupt
    output logic irq
);
    // register state
    logic [7:0] rate_q, rate_d;
    logic [7:0] ctrl_q, ctrl_d;
    logic [7:0] mask_q, mask_d;
    logic [7:0] stat_q, stat_d;
    logic [31:0] prdata_q, prdata_d;
    logic pready_q, pready_d;
    logic rsReq_q, rsReq_d;
    // engine state
    i2crt_pkg::i2crt_state_t state_q, state_d;
    i2crt_pkg::i2crt_act_t act_q, act_d;
    logic [13:0] cnt_q, cnt_d;
    logic [3:0] bit_q, bit_d;
    logic sclLow_q, sclLow_d;
    logic sdaLow_q, sdaLow_d;
    logic [7:0] rateSeen_q, rateSeen_d;
    // derived timing
    i2crt_pkg::i2crt_hold_t tbl;
    logic [1:0] multSh;
    logic [13:0] periodCyc, highCyc, lowCyc, sdaCyc, startCyc, stopCyc;
    // events and handshakes
    logic access, prep, done, hit, master, rsOk, rsGood, rsBad, rsTake, rsWrite;
    logic evByte, evStart, evStop, ackDrive;

    // rate decode
    assign tbl = i2crt_pkg::hold_lookup(rate_q[i2crt_pkg::CODE_HI:0]);
    always_comb begin : rate_multiplier_sel
        case (rate_q[i2crt_pkg::RATE_MULTIPLIER_HI:i2crt_pkg::RATE_MULTIPLIER_LO])
            i2crt_pkg::RATE_MULTIPLIER_X2: multSh = 2'h1;
            i2crt_pkg::RATE_MULTIPLIER_X4: multSh = 2'h2;
            default: multSh = 2'h0;
        endcase
    end
    assign periodCyc = {2'h0, tbl.div} << multSh;
    assign highCyc = periodCyc >> 1;
    assign lowCyc = periodCyc - highCyc;
    assign sdaCyc = {4'h0, tbl.sda} << multSh;
    assign startCyc = {3'h0, tbl.start} << multSh;
    assign stopCyc = {3'h0, tbl.stop} << multSh;

    // apb handshake, one wait state
    assign access = psel & penable;
    assign prep = access & ~pready_q;
    assign done = access & pready_q;
    assign hit = paddr == i2crt_pkg::RATE_OFS || paddr == i2crt_pkg::CTRL_OFS
        || paddr == i2crt_pkg::STAT_OFS || paddr == i2crt_pkg::MASK_OFS;
    assign pready = pready_q;
    assign pslverr = pready_q & ~hit;
    assign prdata = prdata_q;

    assign master = state_q != i2crt_pkg::ST_IDLE;
    assign rsOk = state_q == i2crt_pkg::ST_LOW && bit_q == 4'h0 && act_q == i2crt_pkg::ACT_NONE;
    assign ackDrive = bit_q == i2crt_pkg::ACK_SLOT && !ctrl_q[i2crt_pkg::CTRL_TX]
        && !ctrl_q[i2crt_pkg::CTRL_ACKS];
    // repeat start write while master, judged against the proper point
    assign rsWrite = done && pwrite && paddr == i2crt_pkg::CTRL_OFS
        && pwdata[i2crt_pkg::CTRL_RS] && master;
    assign rsGood = rsWrite & rsOk;
    assign rsBad = rsWrite & ~rsOk;

    // register next state
    always_comb begin : reg_next
        rate_d = rate_q;
        ctrl_d = ctrl_q;
        mask_d = mask_q;
        stat_d = stat_q;
        prdata_d = prdata_q;
        pready_d = prep;
        rsReq_d = rsReq_q & ~rsTake & master;
        if (prep && !pwrite) begin
            case (paddr)
                i2crt_pkg::RATE_OFS: prdata_d = {24'h0, rate_q};
                i2crt_pkg::CTRL_OFS: prdata_d = {24'h0, ctrl_q};
                i2crt_pkg::STAT_OFS: prdata_d = {24'h0, stat_q};
                i2crt_pkg::MASK_OFS: prdata_d = {24'h0, mask_q};
                default: prdata_d = 32'h0;
            endcase
        end
        // read clears only the bits that were reported
        if (done && !pwrite && paddr == i2crt_pkg::STAT_OFS) begin
            stat_d[3:0] = stat_q[3:0] & ~prdata_q[3:0];
        end
        if (done && pwrite) begin
            case (paddr)
                i2crt_pkg::RATE_OFS: rate_d = pwdata[7:0];
                i2crt_pkg::CTRL_OFS: begin
                    ctrl_d = pwdata[7:0];
                    ctrl_d[i2crt_pkg::CTRL_RS] = 1'b0;
                end
                i2crt_pkg::MASK_OFS: mask_d = pwdata[7:0];
                default: rate_d = rate_q;
            endcase
        end
        if (rsGood) begin
            rsReq_d = 1'b1;
        end
        if (rsBad) begin
            ctrl_d[i2crt_pkg::CTRL_MS] = 1'b0;
        end
        // set wins over read clear
        stat_d[i2crt_pkg::ST_BYTE] = stat_d[i2crt_pkg::ST_BYTE] | evByte;
        stat_d[i2crt_pkg::ST_ARB] = stat_d[i2crt_pkg::ST_ARB] | rsBad;
        stat_d[i2crt_pkg::ST_START] = stat_d[i2crt_pkg::ST_START] | evStart;
        stat_d[i2crt_pkg::ST_STOP] = stat_d[i2crt_pkg::ST_STOP] | evStop;
        stat_d[i2crt_pkg::ST_MSTR] = state_d != i2crt_pkg::ST_IDLE;
    end

    always_ff @(posedge clk) begin
        if (!reset_n) begin
            rate_q <= i2crt_pkg::RATE_RST;
            ctrl_q <= i2crt_pkg::CTRL_RST;
            mask_q <= i2crt_pkg::MASK_RST;
            stat_q <= i2crt_pkg::STAT_RST;
            prdata_q <= 32'h0;
            pready_q <= 1'b0;
            rsReq_q <= 1'b0;
        end else begin
            rate_q <= rate_d;
            ctrl_q <= ctrl_d;
            mask_q <= mask_d;
            stat_q <= stat_d;
            prdata_q <= prdata_d;
            pready_q <= pready_d;
            rsReq_q <= rsReq_d;
        end
    end

    assign irq = ctrl_q[i2crt_pkg::CTRL_IE] & |(stat_q[3:0] & mask_q[3:0]);

    // bus engine next state
    always_comb begin : eng_next
        state_d = state_q;
        act_d = act_q;
        cnt_d = cnt_q + 14'h0001;
        bit_d = bit_q;
        sclLow_d = sclLow_q;
        sdaLow_d = sdaLow_q;
        rateSeen_d = rate_q;
        evByte = 1'b0;
        evStart = 1'b0;
        evStop = 1'b0;
        rsTake = 1'b0;
        if (rate_q != rateSeen_q) begin
            cnt_d = 14'h0;
        end
        case (state_q)
            i2crt_pkg::ST_IDLE: begin
                cnt_d = 14'h0;
                bit_d = 4'h0;
                act_d = i2crt_pkg::ACT_NONE;
                sclLow_d = 1'b0;
                sdaLow_d = 1'b0;
                if (ctrl_q[i2crt_pkg::CTRL_MS] && sclIn && sdaIn) begin
                    sdaLow_d = 1'b1;
                    state_d = i2crt_pkg::ST_START_HOLD;
                end
            end
            i2crt_pkg::ST_START_HOLD: begin
                if (cnt_q >= startCyc - 14'h0001) begin
                    sclLow_d = 1'b1;
                    cnt_d = 14'h0;
                    bit_d = 4'h0;
                    act_d = i2crt_pkg::ACT_NONE;
                    evStart = 1'b1;
                    state_d = i2crt_pkg::ST_LOW;
                end
            end
            i2crt_pkg::ST_LOW: begin
                if (cnt_q >= sdaCyc - 14'h0001 && act_q == i2crt_pkg::ACT_NONE) begin
                    if (!ctrl_q[i2crt_pkg::CTRL_MS]) begin
                        act_d = i2crt_pkg::ACT_STOP;
                        sdaLow_d = 1'b1;
                    end else if (rsReq_q) begin
                        act_d = i2crt_pkg::ACT_RS;
                        rsTake = 1'b1;
                        sdaLow_d = 1'b0;
                    end else begin
                        sdaLow_d = ackDrive;
                    end
                end
                if (cnt_q >= lowCyc - 14'h0001) begin
                    sclLow_d = 1'b0;
                    cnt_d = 14'h0;
                    case (act_d)
                        i2crt_pkg::ACT_STOP: state_d = i2crt_pkg::ST_STOP_HIGH;
                        i2crt_pkg::ACT_RS: state_d = i2crt_pkg::ST_RS_HIGH;
                        default: state_d = i2crt_pkg::ST_HIGH;
                    endcase
                end
            end
            i2crt_pkg::ST_HIGH: begin
                if (!sclIn) begin
                    cnt_d = 14'h0;
                end else if (cnt_q >= highCyc - 14'h0001) begin
                    sclLow_d = 1'b1;
                    cnt_d = 14'h0;
                    state_d = i2crt_pkg::ST_LOW;
                    if (bit_q == i2crt_pkg::ACK_SLOT) begin
                        bit_d = 4'h0;
                        evByte = 1'b1;
                    end else begin
                        bit_d = bit_q + 4'h1;
                    end
                end
            end
            i2crt_pkg::ST_STOP_HIGH: begin
                if (!sclIn) begin
                    cnt_d = 14'h0;
                end else if (cnt_q >= stopCyc - 14'h0001) begin
                    sdaLow_d = 1'b0;
                    evStop = 1'b1;
                    state_d = i2crt_pkg::ST_IDLE;
                end
            end
            i2crt_pkg::ST_RS_HIGH: begin
                if (!sclIn) begin
                    cnt_d = 14'h0;
                end else if (cnt_q >= highCyc - 14'h0001) begin
                    sdaLow_d = 1'b1;
                    cnt_d = 14'h0;
                    state_d = i2crt_pkg::ST_START_HOLD;
                end
            end
            default: state_d = i2crt_pkg::ST_IDLE;
        endcase
        // disable or lost arbitration releases both lines at once
        if (!ctrl_q[i2crt_pkg::CTRL_EN] || rsBad) begin
            state_d = i2crt_pkg::ST_IDLE;
            act_d = i2crt_pkg::ACT_NONE;
            cnt_d = 14'h0;
            bit_d = 4'h0;
            sclLow_d = 1'b0;
            sdaLow_d = 1'b0;
        end
    end

    always_ff @(posedge clk) begin
        if (!reset_n) begin
            state_q <= i2crt_pkg::ST_IDLE;
            act_q <= i2crt_pkg::ACT_NONE;
            cnt_q <= 14'h0;
            bit_q <= 4'h0;
            sclLow_q <= 1'b0;
            sdaLow_q <= 1'b0;
            rateSeen_q <= i2crt_pkg::RATE_RST;
        end else begin
            state_q <= state_d;
            act_q <= act_d;
            cnt_q <= cnt_d;
            bit_q <= bit_d;
            sclLow_q <= sclLow_d;
            sdaLow_q <= sdaLow_d;
            rateSeen_q <= rateSeen_d;
        end
    end

    // open-drain pins only ever pull low
    assign sclOut = 1'b0;
    assign sdaOut = 1'b0;
    assign sclOe = sclLow_q;
    assign sdaOe = sdaLow_q;

    // checks
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!reset_n);

    a_rate_table: assert property (rate_q[5:0] == 6'h3f |-> tbl.div == 12'd3840
        && tbl.stop == 11'd1921 && tbl.start == 11'd1918 && tbl.sda == 10'd513)
        else $error("rate table end entry wrong");
    a_disable_idle: assert property (!ctrl_q[7] |=> state_q == i2crt_pkg::ST_IDLE
        && !sclOe && !sdaOe)
        else $error("disabled interface still active");
    a_irq_gate: assert property (!ctrl_q[6] |-> !irq)
        else $error("interrupt without enable");
    a_start_gen: assert property (state_q == i2crt_pkg::ST_IDLE && ctrl_q[7] && ctrl_q[5]
        && sclIn && sdaIn |=> sdaOe && !sclOe ##1 state_q == i2crt_pkg::ST_START_HOLD)
        else $error("start condition not generated");
    a_stop_gen: assert property (state_q == i2crt_pkg::ST_STOP_HIGH && sclIn
        && cnt_q == stopCyc - 14'h0001 |=> !sdaOe && !sclOe && state_q == i2crt_pkg::ST_IDLE)
        else $error("stop condition not generated");
    a_ack_drive: assert property (state_q == i2crt_pkg::ST_HIGH && bit_q == 4'h8 &&
        $stable(ctrl_q) && $past(state_q) == i2crt_pkg::ST_HIGH |-> sdaOe == ackDrive)
        else $error("acknowledge slot level wrong");
    a_rs_accept: assert property (rsGood |=> rsReq_q)
        else $error("repeat start request dropped");
    a_rs_reads0: assert property (pready && psel && !pwrite && paddr == 8'h04 |-> !prdata[2])
        else $error("repeat start bit read as one");
    a_rs_late: assert property (rsBad |=> stat_q[1] && !ctrl_q[5]
        && state_q == i2crt_pkg::ST_IDLE)
        else $error("late repeat start not arbitration loss");
    a_rate_multiplier_x4: assert property (rate_q[7:6] == 2'b10 |-> periodCyc == {tbl.div, 2'b00})
        else $error("multiplier four not applied");
    a_ctrl_reset: assert property ($rose(reset_n) |-> ctrl_q == 8'h00)
        else $error("control not zero after reset");
endmodule : i2crt_rate_ctrl

// ---- testbench.sv ----
// testbench for the two-wire rate and control block
`timescale 1ns/1ps
module testbench;
    logic clk = 0;
    logic reset_n = 0;
    logic [7:0] paddr = 8'h00;
    logic psel = 0, penable = 0, pwrite = 0, stretch = 0, p;
    logic [31:0] pwdata = 32'h0, prdata, r;
    logic pready, pslverr, sclIn, sdaIn, sclOe, sdaOe, irq, err;
    int bad_count = 0, n_checks = 0, n, k;
    logic [7:0] rate [4] = '{8'h00, 8'h41, 8'hbf, 8'hc7};
    int per [4] = '{20, 44, 15360, 40};
    int sth [4] = '{6, 14, 7672, 16};
    logic [31:0] ackc [3] = '{32'ha0, 32'ha8, 32'hb0};
    int acks [3] = '{2, 0, 0};
    i2crt_rate_ctrl uut (.clk(clk), .reset_n(reset_n), .paddr(paddr), .psel(psel),
        .penable(penable), .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .sclIn(sclIn), .sclOut(), .sclOe(sclOe),
        .sdaIn(sdaIn), .sdaOut(), .sdaOe(sdaOe), .irq(irq));
    i2crt_bus_peer peer (.clk(clk), .sclOe(sclOe), .sdaOe(sdaOe), .stretch(stretch),
        .scl(sclIn), .sda(sdaIn));
    initial begin
        forever #25 clk = ~clk;
    end
    task automatic summarize;
        if (bad_count == 0 && n_checks > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask : summarize
    task automatic chk(input logic [31:0] g, input logic [31:0] e);
        n_checks++;
        if (g !== e) begin
            bad_count++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, g, e);
        end
    endtask : chk
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge clk);
        psel <= 1;
        penable <= 0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clk);
        penable <= 1;
        do @(negedge clk); while (pready !== 1'b1);
        r = prdata;
        err = pslverr;
        @(posedge clk);
        psel <= 0;
        penable <= 0;
    endtask : apb
    task automatic wc(input logic [31:0] d);
        apb(1, i2crt_pkg::CTRL_OFS, d);
    endtask : wc
    task automatic waitv(ref logic s, input logic v);
        n = 0;
        do begin
            @(negedge clk);
            n++;
        end while (s !== v && n < 20000);
        if (s !== v) begin
            chk(s, v);
        end
    endtask : waitv
    task automatic settle;
        @(posedge clk);
        @(negedge clk);
    endtask : settle
    initial begin
        repeat (5) @(posedge clk);
        reset_n <= 1;
        for (int i = 0; i < 4; i++) begin
            apb(0, 8'(4 * i), 0);
            chk(r, 0);
        end
        apb(1, 8'h10, 32'hff);
        chk(err, 1);
        wc(32'h07);
        apb(0, 8'h10, 0);
        chk(err, 1);
        chk(r, 0);
        apb(0, i2crt_pkg::CTRL_OFS, 0);
        chk(r, 32'h03);
        stretch <= 1;
        wc(32'hb0);
        waitv(sclOe, 1);
        waitv(sclOe, 0);
        waitv(sclOe, 1);
        chk(n > 10 && n < 14, 1);
        stretch <= 0;
        wc(0);
        for (int i = 0; i < 4; i++) begin
            apb(1, i2crt_pkg::RATE_OFS, {24'h0, rate[i]});
            wc(32'hb0);
            waitv(sdaOe, 1);
            waitv(sclOe, 1);
            chk(n, sth[i]);
            waitv(sclOe, 0);
            chk(n, per[i] - per[i] / 2);
            waitv(sclOe, 1);
            chk(n, per[i] / 2);
            wc(0);
            settle();
            chk({sclOe, sdaOe}, 0);
        end
        apb(1, i2crt_pkg::MASK_OFS, 32'h1);
        wc(32'hb0);
        waitv(sclOe, 1);
        wc(32'hb4);
        waitv(sclOe, 0);
        waitv(sdaOe, 1);
        chk(n, 20);
        repeat (400) @(negedge clk);
        chk(irq, 0);
        wc(32'hf0);
        settle();
        chk(irq, 1);
        apb(0, i2crt_pkg::STAT_OFS, 0);
        chk(r & 32'h17, 32'h15);
        settle();
        chk(irq, 0);
        wc(0);
        wc(32'hb0);
        waitv(sdaOe, 1);
        wc(32'hb4);
        settle();
        chk({sclOe, sdaOe}, 0);
        apb(0, i2crt_pkg::STAT_OFS, 0);
        chk(r & 32'h2, 32'h2);
        apb(0, i2crt_pkg::CTRL_OFS, 0);
        chk(r & 32'h24, 0);
        wc(32'hb0);
        waitv(sclOe, 1);
        wc(32'h90);
        waitv(sdaOe, 1);
        waitv(sclOe, 0);
        waitv(sdaOe, 0);
        chk(n, 21);
        apb(0, i2crt_pkg::STAT_OFS, 0);
        chk(r & 32'h18, 32'h08);
        for (int i = 0; i < 3; i++) begin
            wc(ackc[i]);
            waitv(sclOe, 1);
            k = 0;
            p = sdaOe;
            repeat (740) begin
                @(negedge clk);
                k += int'(sdaOe === 1'b1 && p === 1'b0);
                p = sdaOe;
            end
            chk(k, acks[i]);
            wc(0);
        end
        summarize();
    end
    initial begin
        repeat (80000) @(posedge clk);
        bad_count++;
        summarize();
    end
endmodule : testbench
